// File: src/scrp_pkg.sv
// Constants for the serial configuration register port.
package scrp_pkg;
  localparam int         FRAME_BITS   = 32;
  localparam int         HDR_BITS     = 12;
  localparam int         ADDR_BITS    = 4;
  localparam int         DATA_BITS    = 16;
  localparam logic [11:0] HDR_PATTERN = 12'h001;
  localparam logic [5:0] CNT_RESET    = 6'h00;
  localparam logic [5:0] CNT_LAST     = 6'h1F;
  localparam logic [5:0] CNT_HDR_LAST = 6'h0B;
  // Clock edges the strap needs to cross its synchroniser after reset.
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  // Register offsets.
  localparam logic [3:0] ADDR_OUT_CFG    = 4'h1;
  localparam logic [3:0] ADDR_I_OFFSET   = 4'h2;
  localparam logic [3:0] ADDR_I_GAIN     = 4'h3;
  localparam logic [3:0] ADDR_Q_OFFSET   = 4'hA;
  localparam logic [3:0] ADDR_Q_GAIN     = 4'hB;
  localparam logic [3:0] ADDR_DES_ENABLE = 4'hD;
  localparam logic [3:0] ADDR_DES_COARSE = 4'hE;
  localparam logic [3:0] ADDR_DES_FINE   = 4'hF;
  // Power-on values.
  localparam logic [15:0] RST_OUT_CFG    = 16'hB2FF;
  localparam logic [15:0] RST_OFFSET     = 16'h007F;
  localparam logic [15:0] RST_GAIN       = 16'h807F;
  localparam logic [15:0] RST_DES_ENABLE = 16'h0000;
  localparam logic [15:0] RST_DES_COARSE = 16'h0000;
  localparam logic [15:0] RST_DES_FINE   = 16'h0000;
  // Configuration field positions.
  localparam int BIT_DUTY_STAB = 12;
  localparam int BIT_DDR_PHASE = 11;
  localparam int BIT_SINGLE    = 10;
  localparam int BIT_SWING     = 9;
  localparam int BIT_EDGE      = 8;
endpackage : scrp_pkg

// File: src/scrp_port.sv
// Serial configuration register port with its eight write-only registers.
// Notes on behaviour
// - Serial port is accepted only in extended control mode; ignored otherwise.
// - One data bit captured per rising serial clock edge while selected.
// - Frame is exactly 32 bits, most significant bit first.
// - First 12 bits are eleven zeros then a one.
// - Header is followed by 4 address bits and 16 data bits.
// - Address decodes 1,2,3,A,B,D,E,F; others reserved.
// - Next frame may start at bit 33 without deselect.
// - Eight write-only registers, no read-back, inert in normal mode.
// - Configuration bit 12 enables duty-cycle stabilizer, resets to one.
// - Bit 11 chooses double-rate clock phase, resets to zero.
// - Bit 10 clear selects double rate, set single rate; resets zero.
// - Bit 9 set standard swing, clear reduced; resets to one.
// - Bit 8 picks single-rate data edge; resets to zero.
// - Power-on loads configuration 0xB2FF and documented defaults elsewhere.
`timescale 1ns/1ns
`default_nettype none

module scrp_port (
  // Clock, reset and enable
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // Serial link pins
  input  wire logic        ser_clk,
  input  wire logic        ser_sel_n,
  input  wire logic        ser_din,
  // Mode strap and normal-mode pins
  input  wire logic        extended_ctrl_strap,
  input  wire logic        single_rate_pin,
  input  wire logic        edge_select_pin,
  input  wire logic        swing_select_pin,
  // Effective output controls
  output logic             duty_stabilizer_en,
  output logic             ddr_phase_sel,
  output logic             single_rate_sel,
  output logic             out_swing_sel,
  output logic             out_edge_sel,
  // Analog trim values
  output logic [15:0]      i_offset_word,
  output logic [15:0]      i_gain_word,
  output logic [15:0]      q_offset_word,
  output logic [15:0]      q_gain_word,
  output logic [15:0]      des_enable_word,
  output logic [15:0]      des_coarse_word,
  output logic [15:0]      des_fine_word,
  // Frame status
  output logic             frame_done,
  output logic             frame_error
);

  // Two-stage synchronisers for the serial pins and the strap; the normal-mode pins pass through three stages.
  logic [1:0] sclk_sync_reg;
  logic [1:0] sel_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] strap_sync_reg;
  logic [1:0] pins_meta_reg [3];
  logic [2:0] pins_sync_reg;
  logic       sclk_prev_reg;
  logic       ext_mode_reg;
  logic       strap_taken_reg;
  logic [1:0] strap_age_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_sync_reg  <= 2'h0;
      sel_sync_reg   <= 2'h3;
      din_sync_reg   <= 2'h0;
      strap_sync_reg <= 2'h0;
      sclk_prev_reg  <= 1'b0;
    end else if (ce) begin
      sclk_sync_reg  <= {sclk_sync_reg[0], ser_clk};
      sel_sync_reg   <= {sel_sync_reg[0], ser_sel_n};
      din_sync_reg   <= {din_sync_reg[0], ser_din};
      strap_sync_reg <= {strap_sync_reg[0], extended_ctrl_strap};
      sclk_prev_reg  <= sclk_sync_reg[1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 3; i++) begin
        pins_meta_reg[i] <= 2'h0;
      end
      pins_sync_reg <= 3'h0;
    end else if (ce) begin
      pins_meta_reg[0] <= {pins_meta_reg[0][0], single_rate_pin};
      pins_meta_reg[1] <= {pins_meta_reg[1][0], edge_select_pin};
      pins_meta_reg[2] <= {pins_meta_reg[2][0], swing_select_pin};
      pins_sync_reg    <= {pins_meta_reg[2][1], pins_meta_reg[1][1], pins_meta_reg[0][1]};
    end
  end

  // The strap is a fixed selection, so it is caught once after reset and held.
  // Capture waits until the synchroniser holds the pin, not its reset value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_mode_reg    <= 1'b0;
      strap_taken_reg <= 1'b0;
      strap_age_reg   <= 2'h0;
    end else if (ce && !strap_taken_reg) begin
      if (strap_age_reg == scrp_pkg::STRAP_SETTLE) begin
        ext_mode_reg    <= strap_sync_reg[1];
        strap_taken_reg <= 1'b1;
      end else begin
        strap_age_reg <= strap_age_reg + 2'h1;
      end
    end
  end

  logic sclk_rise;
  logic selected;
  assign sclk_rise = sclk_sync_reg[1] & ~sclk_prev_reg;
  assign selected  = ~sel_sync_reg[1] & ext_mode_reg;

  // Frame shifter.
  logic [5:0]  bit_cnt_reg;
  logic [30:0] shift_reg;
  logic        hdr_bad_reg;
  logic        wr_pulse_reg;
  logic [3:0]  wr_addr_reg;
  logic [15:0] wr_data_reg;
  logic        hdr_bad_next;
  logic [31:0] frame_word;

  // Header bit expected at a given position of the first twelve.
  function automatic logic hdr_bit(input logic [5:0] pos);
    hdr_bit = scrp_pkg::HDR_PATTERN[4'(scrp_pkg::CNT_HDR_LAST - pos)];
  endfunction

  assign frame_word = {shift_reg, din_sync_reg[1]};

  always_comb begin
    hdr_bad_next = hdr_bad_reg;
    if (bit_cnt_reg == scrp_pkg::CNT_RESET) begin
      hdr_bad_next = 1'b0;
    end
    if (bit_cnt_reg <= scrp_pkg::CNT_HDR_LAST && din_sync_reg[1] != hdr_bit(bit_cnt_reg)) begin
      hdr_bad_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_reg  <= scrp_pkg::CNT_RESET;
      shift_reg    <= 31'h00000000;
      hdr_bad_reg  <= 1'b0;
      wr_pulse_reg <= 1'b0;
      wr_addr_reg  <= 4'h0;
      wr_data_reg  <= 16'h0000;
      frame_done   <= 1'b0;
      frame_error  <= 1'b0;
    end else if (ce) begin
      wr_pulse_reg <= 1'b0;
      frame_done   <= 1'b0;
      frame_error  <= 1'b0;
      if (!selected) begin
        // Early deselect drops a partial frame.
        if (bit_cnt_reg != scrp_pkg::CNT_RESET) begin
          frame_error <= 1'b1;
        end
        bit_cnt_reg <= scrp_pkg::CNT_RESET;
        hdr_bad_reg <= 1'b0;
      end else if (sclk_rise) begin
        shift_reg   <= frame_word[30:0];
        hdr_bad_reg <= hdr_bad_next;
        if (bit_cnt_reg == scrp_pkg::CNT_LAST) begin
          bit_cnt_reg <= scrp_pkg::CNT_RESET;
          frame_done  <= ~hdr_bad_next;
          frame_error <= hdr_bad_next;
          wr_pulse_reg <= ~hdr_bad_next;
          wr_addr_reg <= frame_word[19:16];
          wr_data_reg <= frame_word[15:0];
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
        end
      end
    end
  end

  // Write-only register bank; no path reads these back.
  logic [15:0] cfg_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg         <= scrp_pkg::RST_OUT_CFG;
      i_offset_word   <= scrp_pkg::RST_OFFSET;
      i_gain_word     <= scrp_pkg::RST_GAIN;
      q_offset_word   <= scrp_pkg::RST_OFFSET;
      q_gain_word     <= scrp_pkg::RST_GAIN;
      des_enable_word <= scrp_pkg::RST_DES_ENABLE;
      des_coarse_word <= scrp_pkg::RST_DES_COARSE;
      des_fine_word   <= scrp_pkg::RST_DES_FINE;
    end else if (ce && wr_pulse_reg) begin
      unique case (wr_addr_reg)
        scrp_pkg::ADDR_OUT_CFG:    cfg_reg         <= wr_data_reg;
        scrp_pkg::ADDR_I_OFFSET:   i_offset_word   <= wr_data_reg;
        scrp_pkg::ADDR_I_GAIN:     i_gain_word     <= wr_data_reg;
        scrp_pkg::ADDR_Q_OFFSET:   q_offset_word   <= wr_data_reg;
        scrp_pkg::ADDR_Q_GAIN:     q_gain_word     <= wr_data_reg;
        scrp_pkg::ADDR_DES_ENABLE: des_enable_word <= wr_data_reg;
        scrp_pkg::ADDR_DES_COARSE: des_coarse_word <= wr_data_reg;
        scrp_pkg::ADDR_DES_FINE:   des_fine_word   <= wr_data_reg;
        default: ;
      endcase
    end
  end

  // Effective controls: register bits in extended mode, pins in normal mode.
  // Normal mode has no duty stabilizer control and only zero DDR phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      duty_stabilizer_en <= 1'b1;
      ddr_phase_sel      <= 1'b0;
      single_rate_sel    <= 1'b0;
      out_swing_sel      <= 1'b1;
      out_edge_sel       <= 1'b0;
    end else if (ce) begin
      if (ext_mode_reg) begin
        duty_stabilizer_en <= cfg_reg[scrp_pkg::BIT_DUTY_STAB];
        ddr_phase_sel      <= ~cfg_reg[scrp_pkg::BIT_SINGLE] & cfg_reg[scrp_pkg::BIT_DDR_PHASE];
        single_rate_sel    <= cfg_reg[scrp_pkg::BIT_SINGLE];
        out_swing_sel      <= cfg_reg[scrp_pkg::BIT_SWING];
        out_edge_sel       <= cfg_reg[scrp_pkg::BIT_EDGE];
      end else begin
        duty_stabilizer_en <= 1'b1;
        ddr_phase_sel      <= 1'b0;
        single_rate_sel    <= pins_sync_reg[0];
        out_edge_sel       <= pins_sync_reg[1];
        out_swing_sel      <= pins_sync_reg[2];
      end
    end
  end

endmodule : scrp_port

`default_nettype wire

// File: sim/scrp_monitor.sv
// Checker of the serial configuration port outputs.
`timescale 1ns/1ns
`default_nettype none
module scrp_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Watched pins
  input wire logic        ser_clk,
  input wire logic        ser_sel_n,
  input wire logic        extended_ctrl_strap,
  input wire logic        duty_stabilizer_en,
  input wire logic        ddr_phase_sel,
  input wire logic        single_rate_sel,
  input wire logic [15:0] i_gain_word,
  input wire logic        frame_done,
  input wire logic        frame_error
);
  logic [3:0] rise_age;
  // Saturates so a stale serial edge can never look recent.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rise_age <= 4'hF;
    else if ($rose(ser_clk)) rise_age <= 4'h0;
    else if (rise_age != 4'hF) rise_age <= rise_age + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  done_err_excl_a: assert property (!(frame_done && frame_error)) else $error("done with error");
  done_pulse_a: assert property (frame_done |=> !frame_done) else $error("done too long");
  error_pulse_a: assert property (frame_error |=> !frame_error) else $error("error too long");
  done_after_rise_a: assert property (frame_done |-> rise_age >= 4'h1 && rise_age <= 4'h7) else $error("late done");
  done_selected_a: assert property (frame_done |-> $past(ser_sel_n, 2) == 1'b0) else $error("done unselected");
  mode_quiet_a: assert property (!extended_ctrl_strap |-> !frame_done && duty_stabilizer_en) else $error("normal");
  word_write_a: assert property ($changed(i_gain_word) |-> $past(frame_done)) else $error("word moved");
  cfg_apply_a: assert property (extended_ctrl_strap && $changed(single_rate_sel) |-> $past(frame_done, 2))
    else $error("cfg moved");
  phase_ddr_a: assert property (ddr_phase_sel |-> !single_rate_sel) else $error("phase in single");
endmodule // scrp_monitor
bind scrp_port scrp_monitor chk (.clk, .rst, .ser_clk, .ser_sel_n, .extended_ctrl_strap, .duty_stabilizer_en,
  .ddr_phase_sel, .single_rate_sel, .i_gain_word, .frame_done, .frame_error);
`default_nettype wire

// File: sim/scrp_host.sv
// Host model that shifts frames into the serial configuration port.
`timescale 1ns/1ns
`default_nettype none
module scrp_host (
  // Serial link pins
  output logic ser_clk,
  output logic ser_sel_n,
  output logic ser_din
);
  initial begin
    ser_clk = 1'b0;
    ser_sel_n = 1'b1;
    ser_din = 1'b1;
  end
  // Select stays low across calls, so frames run back to back.
  // No calibration is modelled, so writes never overlap one.
  task automatic shift(input logic [31:0] w, input int n);
    #1;
    for (int i = 31; i > 31 - n; i--) begin
      ser_sel_n = 1'b0;
      ser_din = w[i];
      #160 ser_clk = 1'b1;
      #160 ser_clk = 1'b0;
    end
  endtask
  task automatic frame(input logic [3:0] a, input logic [15:0] d);
    shift({12'h001, a, d}, 32);
  endtask
  // The line toggles on release so a stale bit never looks held.
  task automatic release_sel();
    #40 ser_sel_n = 1'b1;
    ser_din = ~ser_din;
    // Stay deselected long enough for the synchroniser to see it.
    #120;
  endtask
endmodule // scrp_host
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the serial configuration register port.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin failures++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, g, x); end end
module testbench;
  logic clk, rst, extended_ctrl_strap, single_rate_pin, edge_select_pin, swing_select_pin;
  logic ser_clk, ser_sel_n, ser_din, frame_done, frame_error;
  logic duty_stabilizer_en, ddr_phase_sel, single_rate_sel, out_swing_sel, out_edge_sel;
  logic [15:0] w [7];
  logic [15:0] e [7];
  logic [3:0]  adr [7] = '{4'h2, 4'h3, 4'hA, 4'hB, 4'hD, 4'hE, 4'hF};
  logic [3:0]  rsv [8] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hC};
  int failures, samples_checked, dones, errs, ed, ee;
  scrp_host host (.ser_clk, .ser_sel_n, .ser_din);
  scrp_port dut (.*, .ce(1'b1), .i_offset_word(w[0]), .i_gain_word(w[1]), .q_offset_word(w[2]),
    .q_gain_word(w[3]), .des_enable_word(w[4]), .des_coarse_word(w[5]), .des_fine_word(w[6]));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    dones += frame_done;
    errs += frame_error;
  end
  task automatic do_reset(input logic mode);
    @(posedge clk) #1 rst = 1'b1;
    extended_ctrl_strap = mode;
    e = '{16'h007F, 16'h807F, 16'h007F, 16'h807F, 16'h0000, 16'h0000, 16'h0000};
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic check(input logic [4:0] c, input string name);
    host.release_sel();
    repeat (8) @(posedge clk);
    for (int i = 0; i < 7; i++) `CHK(w[i], e[i])
    `CHK({duty_stabilizer_en, ddr_phase_sel, single_rate_sel, out_swing_sel, out_edge_sel}, c)
    `CHK(dones, ed)
    `CHK(errs, ee)
    $display("test %s ended", name);
  endtask
  task automatic complete_run();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    extended_ctrl_strap = 1'b1;
    single_rate_pin = 1'b0;
    edge_select_pin = 1'b0;
    swing_select_pin = 1'b0;
    do_reset(1'b1);
    check(5'b10010, "por");
    host.frame(4'h1, 16'hA9FF);
    ed++;
    check(5'b01001, "cfg_a");
    host.frame(4'h1, 16'hBDFF);
    ed++;
    check(5'b10101, "cfg_b");
    for (int i = 0; i < 7; i++) begin
      e[i] = 16'h137F + 16'h1100 * i;
      host.frame(adr[i], e[i]);
    end
    ed += 7;
    check(5'b10101, "regs");
    for (int i = 0; i < 8; i++) host.frame(rsv[i], 16'h0000);
    ed += 8;
    check(5'b10101, "reserved");
    host.shift({12'h002, 4'h2, 16'h1234}, 32);
    ee++;
    check(5'b10101, "bad_header");
    host.frame(4'h3, 16'hFFFF);
    e[1] = 16'hFFFF;
    ed++;
    host.release_sel();
    host.shift({12'h001, 4'h2, 16'h1234}, 20);
    ee++;
    check(5'b10101, "early_release");
    do_reset(1'b0);
    @(posedge clk) #1 single_rate_pin = 1'b1;
    edge_select_pin = 1'b1;
    host.frame(4'h2, 16'hFFFF);
    check(5'b10101, "normal");
    complete_run();
  end
  initial begin
    #1000000;
    failures++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
